// ### logic/octal_reg_defines.svh
/*
 Constants for the octal clear/hold bus register with its AXI4-Lite window.
 Assumes it is included by bare name from files under logic/.
*/
// What this block does
// (RQ1) Eight edge-triggered storage bits hold one 8-bit word, each bit feeding its own bus output.
// (RQ2) One clock edge and one shared output-enable path act on all eight bits together.
// (RQ3) On a rising clock edge where capture is allowed each bit takes its own data input.
// (RQ4) The stored word is driven out only while all three active-low drive gates are low.
// (RQ5) If any drive gate is high all eight outputs float.
// (RQ6) Drive gate changes never touch the stored word, which keeps loading, holding or clearing.
// (RQ7) A low zeroize input forces every stored bit to zero.
// (RQ8) Loads happen only while zeroize is high; clock edges during zeroize load nothing.
// (RQ9) With zeroize high and hold low the inputs load on the rising edge and show when driven.
// (RQ10) While hold is high the stored word stays unchanged whatever data or clock do.
// (RQ11) Zeroize acts without a clock edge and wins over hold and data.
// (RQ12) The controlling logic keeps data and hold stable around each rising edge it means to use.
`ifndef OCTAL_REG_DEFINES_SVH
`define OCTAL_REG_DEFINES_SVH

`define DATA_W 8
`define GATE_N 3
`define SYNC_W 14
// Sync vector layout: data, three gates, hold, zeroize, edge clock
`define SY_DATA_LSB 0
`define SY_GATE_LSB 8
`define SY_HOLD 11
`define SY_ZERO 12
`define SY_EDGE 13
// Idle pin levels: gates, hold and zeroize high, data and clock low
`define SYNC_RST 14'h1F00

`define ADDR_W 4
`define AXI_DW 32
`define CTRL_OFF 4'h0
`define STAT_OFF 4'h4
`define CNT_OFF 4'h8
`define CTRL_W 3
`define CTRL_RST 3'h0
`define CTRL_HOLD 0
`define CTRL_ZERO 1
`define CTRL_FLOAT 2
`define ST_WORD_LSB 0
`define ST_DRIVE 8
`define ST_ZERO 9
`define ST_HOLD 10
`define ST_SEEN 16
`define ST_SEEN_LANE 2
`define CTRL_LANE 0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define WORD_RST 8'h00
`define CNT_ONE 32'h00000001
`define CNT_RST 32'h00000000

`endif

// ### logic/octal_reg_pkg.sv
/*
 Types shared by the octal register files.
 Assumes octal_reg_defines.svh sits beside it.
*/
`include "octal_reg_defines.svh"

package octal_reg_pkg;
    typedef logic [`DATA_W-1:0] word_t;
    typedef logic [`SYNC_W-1:0] sync_t;
    typedef logic [1:0] resp_t;
    typedef logic [`AXI_DW-1:0] bus_word_t;
    typedef logic [`ADDR_W-1:0] addr_t;
    typedef logic [2:0] sel_t;
endpackage : octal_reg_pkg

// ### logic/pin_sync.sv
/*
 Two-flop synchroniser for a group of pin inputs.
 Assumes the pins are asynchronous to aclk; each bit is synchronised alone,
 so bits that change together may land one cycle apart.
*/
`timescale 1ns/100ps

module pin_sync
    import octal_reg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire sync_t pins,
    output sync_t pins_s
);
    sync_t meta_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= `SYNC_RST;
            pins_s <= `SYNC_RST;
        end else if (ce) begin
            meta_q <= pins;
            pins_s <= meta_q;
        end
    end
endmodule : pin_sync

// ### logic/word_store.sv
/*
 The eight storage bits with clear and load.
 Assumes zero and load are already synchronous to aclk.
*/
`timescale 1ns/100ps

module word_store
    import octal_reg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic zero,
    input wire logic load,
    input wire word_t d,
    output word_t word_q
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            word_q <= `WORD_RST;
        end else if (ce) begin
            if (zero) begin
                word_q <= `WORD_RST; // see RQ7 see RQ11
            end else if (load) begin
                word_q <= d; // see RQ1 see RQ3
            end
        end
    end
endmodule : word_store

// ### logic/octal_register.sv
/*
 Octal bus register with zeroize, hold and three drive gates, plus an
 AXI4-Lite window for software hold, zeroize and float, status and a load count.
 Assumes all pin inputs are asynchronous to aclk and that the outer pad ring
 resolves q_bus from q_bus_o and q_bus_oe_n.
*/
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

module octal_register
    import octal_reg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic edge_clock,
    input wire word_t data_in,
    input wire logic zeroize_n,
    input wire logic hold_n,
    input wire logic drive_gate_1_n,
    input wire logic drive_gate_2_n,
    input wire logic drive_gate_3_n,
    output word_t q_bus_o,
    output logic q_bus_oe_n,
    input wire logic awvalid,
    output logic awready,
    input wire addr_t awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire bus_word_t wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output resp_t bresp,
    input wire logic arvalid,
    output logic arready,
    input wire addr_t araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output bus_word_t rdata,
    output resp_t rresp
);
    sync_t pins_s;
    logic edge_prev_q;
    logic rise;
    logic zero_act;
    logic hold_act;
    logic float_req;
    logic load_evt;
    word_t data_s;
    logic [`CTRL_W-1:0] ctrl_q;
    logic seen_q;
    bus_word_t cnt_q;
    bus_word_t status_w;
    addr_t awaddr_q;
    bus_word_t wdata_q;
    logic [3:0] wstrb_q;
    logic aw_got_q;
    logic w_got_q;
    logic write_go;
    sel_t wsel;
    sel_t rsel;

    // One-hot register select; zero means unmapped
    function automatic sel_t decode(input addr_t a);
        sel_t s;
        s = 3'h0;
        case (a)
            `CTRL_OFF: s = 3'h1;
            `STAT_OFF: s = 3'h2;
            `CNT_OFF: s = 3'h4;
            default: s = 3'h0;
        endcase
        return s;
    endfunction : decode

    pin_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .pins({edge_clock, zeroize_n, hold_n, drive_gate_3_n, drive_gate_2_n,
               drive_gate_1_n, data_in}),
        .pins_s(pins_s)
    );

    // Edge detect on the synchronised clock only, never on the first flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            edge_prev_q <= 1'b0;
        end else if (ce) begin
            edge_prev_q <= pins_s[`SY_EDGE];
        end
    end

    // Data goes through the same two stages as the clock, so the word seen
    // with the edge is the word that stood at the pin edge. The far side must
    // hold data and hold_n a full aclk period around its edge for this to work.
    assign rise = pins_s[`SY_EDGE] && !edge_prev_q; // see RQ2 see RQ12
    assign data_s = pins_s[`SY_DATA_LSB +: `DATA_W];
    assign zero_act = !pins_s[`SY_ZERO] || ctrl_q[`CTRL_ZERO];
    // The hold pin freezes the word while it is high, so its level is used as is
    assign hold_act = pins_s[`SY_HOLD] || ctrl_q[`CTRL_HOLD];
    assign float_req = (|pins_s[`SY_GATE_LSB +: `GATE_N]) || ctrl_q[`CTRL_FLOAT];
    // Zeroize wins over everything; hold blocks an edge
    assign load_evt = rise && !hold_act && !zero_act; // see RQ8 see RQ9 see RQ10 see RQ11

    word_store u_store (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .zero(zero_act),
        .load(load_evt),
        .d(data_s),
        .word_q(q_bus_o)
    );

    // One shared enable for all eight outputs; gates never reach the store
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_bus_oe_n <= 1'b1;
        end else if (ce) begin
            q_bus_oe_n <= float_req; // see RQ2 see RQ4 see RQ5 see RQ6
        end
    end

    // Write address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            aw_got_q <= 1'b0;
            awaddr_q <= `CTRL_OFF;
        end else if (ce) begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_got_q <= 1'b1;
                awaddr_q <= awaddr;
            end else if (write_go) begin
                aw_got_q <= 1'b0;
            end else if (!aw_got_q && !awready && !bvalid) begin
                awready <= 1'b1;
            end
        end
    end

    // Write data channel, taken independently of the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready <= 1'b0;
            w_got_q <= 1'b0;
            wdata_q <= `CNT_RST;
            wstrb_q <= 4'h0;
        end else if (ce) begin
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_got_q <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end else if (write_go) begin
                w_got_q <= 1'b0;
            end else if (!w_got_q && !wready && !bvalid) begin
                wready <= 1'b1;
            end
        end
    end

    assign write_go = aw_got_q && w_got_q && !bvalid;
    assign wsel = decode(awaddr_q);

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else if (ce) begin
            if (write_go) begin
                bvalid <= 1'b1;
                bresp <= (wsel == 3'h0) ? `RESP_SLVERR : `RESP_OKAY;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Control: software hold, zeroize and float
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `CTRL_RST;
        end else if (ce && write_go && wsel[0] && wstrb_q[`CTRL_LANE]) begin
            ctrl_q <= wdata_q[`CTRL_W-1:0];
        end
    end

    // Sticky load flag, write one to clear; a load in the clearing cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seen_q <= 1'b0;
        end else if (ce) begin
            if (load_evt) begin
                seen_q <= 1'b1;
            end else if (write_go && wsel[1] && wstrb_q[`ST_SEEN_LANE]
                         && wdata_q[`ST_SEEN]) begin
                seen_q <= 1'b0;
            end
        end
    end

    // Load counter, any write to it clears it; a load in that cycle counts as one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= `CNT_RST;
        end else if (ce) begin
            if (write_go && wsel[2]) begin
                cnt_q <= load_evt ? `CNT_ONE : `CNT_RST;
            end else if (load_evt) begin
                cnt_q <= cnt_q + `CNT_ONE;
            end
        end
    end

    always_comb begin
        status_w = `CNT_RST;
        status_w[`ST_WORD_LSB +: `DATA_W] = q_bus_o;
        status_w[`ST_DRIVE] = !q_bus_oe_n;
        status_w[`ST_ZERO] = zero_act;
        status_w[`ST_HOLD] = hold_act;
        status_w[`ST_SEEN] = seen_q;
    end

    assign rsel = decode(araddr);

    // Read address and data; data registered in the handshake cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
        end else if (ce) begin
            if (arvalid && arready) begin
                arready <= 1'b0;
            end else if (!arready && !rvalid) begin
                arready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= `CNT_RST;
            rresp <= `RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp <= (rsel == 3'h0) ? `RESP_SLVERR : `RESP_OKAY;
                case (rsel)
                    3'h1: rdata <= {{(`AXI_DW-`CTRL_W){1'b0}}, ctrl_q};
                    3'h2: rdata <= status_w;
                    3'h4: rdata <= cnt_q;
                    default: rdata <= `CNT_RST;
                endcase
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);

    sequence s_clear_seen;
        zero_act;
    endsequence

    sequence s_edge_free;
        rise && !hold_act && !zero_act;
    endsequence

    sequence s_edge_held;
        rise && hold_act && !zero_act;
    endsequence

    sequence s_edge_zeroed;
        rise && zero_act;
    endsequence

    sequence s_clear_over_hold;
        zero_act && hold_act && q_bus_o != `WORD_RST;
    endsequence

    // Load results are checked one cycle on, so the gates and the
    // zeroize must stay quiet for that cycle too
    sequence s_open_after_load;
        !float_req && !zero_act;
    endsequence

    // Storage keeps working behind a floating bus
    sequence s_float_clear;
        zero_act && float_req;
    endsequence

    sequence s_both_taken;
        aw_got_q && w_got_q && !bvalid;
    endsequence

    a_clear_zeroes: assert property (s_clear_seen |=> q_bus_o == `WORD_RST) // see RQ7
        else $error("stored word not zero after zeroize");

    a_clear_blocks_load: assert property (s_edge_zeroed |=> // see RQ8
                                          q_bus_o == `WORD_RST && !$changed(cnt_q))
        else $error("edge during zeroize loaded data");

    a_clear_beats_hold: assert property (s_clear_over_hold |=> q_bus_o == `WORD_RST) // see RQ11
        else $error("zeroize did not win over hold");

    a_load_takes_data: assert property (s_edge_free |=> q_bus_o == $past(data_s)) // see RQ3
        else $error("loaded word differs from data at edge");

    a_load_then_drive: assert property ((s_edge_free ##1 s_open_after_load) |=> // see RQ9
                                        !q_bus_oe_n && q_bus_o == $past(data_s, 2))
        else $error("loaded word not driven while gates open");

    a_hold_keeps_word: assert property ((hold_act && !zero_act) |=> $stable(q_bus_o)) // see RQ10
        else $error("word changed during hold");

    a_drive_all_low: assert property (!float_req |=> !q_bus_oe_n) // see RQ4
        else $error("outputs not driven with all gates low");

    a_float_any_high: assert property (float_req |=> q_bus_oe_n) // see RQ5
        else $error("outputs driven with a gate high");

    a_gate_no_store: assert property (($changed(float_req) && !rise && !zero_act) // see RQ6
                                      |=> $stable(q_bus_o))
        else $error("gate change altered stored word");

    a_word_one_edge: assert property (!rise && !zero_act |=> $stable(q_bus_o)) // see RQ2
        else $error("word changed without a shared clock edge");

    a_hold_blocks_edge: assert property (s_edge_held |=> // see RQ10
                                         $stable(q_bus_o) && !$rose(seen_q))
        else $error("edge during hold loaded data");

    a_float_clears: assert property (s_float_clear |=> // see RQ6
                                     q_bus_o == `WORD_RST && q_bus_oe_n)
        else $error("zeroize lost while outputs float");

    a_float_loads: assert property ((s_edge_free ##0 float_req) |=> // see RQ6
                                    q_bus_oe_n && q_bus_o == $past(data_s))
        else $error("load lost while outputs float");

    a_zero_driven: assert property ((s_clear_seen ##1 (zero_act && !float_req)) |=> // see RQ7
                                    !q_bus_oe_n && q_bus_o == `WORD_RST)
        else $error("zeroed word not driven while gates open");

    a_resp_follows: assert property (s_both_taken |=> bvalid ##0 (!awready && !wready)) // AXI4-Lite write response
        else $error("write response did not follow both channels");
endmodule : octal_register

// ### bench/pin_partner.sv
/*
 Controlling logic on the pin side of the octal register: clock, data, hold,
 zeroize and the three drive gates.
 Assumes its tasks are called from one process right after a rising aclk.
*/
`timescale 1ns/100ps

module pin_partner
    import octal_reg_pkg::*;
(
    input wire logic aclk,
    output logic edge_clock,
    output word_t data_in,
    output logic zeroize_n,
    output logic hold_n,
    output logic [2:0] gate_n
);
    initial begin
        edge_clock = 1'b0;
        data_in = 8'h00;
        zeroize_n = 1'b1;
        hold_n = 1'b0;
        gate_n = 3'h7;
    end

    // Levels are left to settle through the synchronisers before returning
    task automatic pins(input logic z, input logic h, input logic [2:0] g);
        zeroize_n <= z;
        hold_n <= h;
        gate_n <= g;
        repeat (6) @(posedge aclk);
    endtask : pins

    // Data scrambled after the hold window so a late sample is caught
    task automatic pulse(input word_t d);
        data_in <= d;
        repeat (2) @(posedge aclk);
        edge_clock <= 1'b1;
        repeat (3) @(posedge aclk);
        edge_clock <= 1'b0;
        data_in <= ~d;
        repeat (6) @(posedge aclk);
    endtask : pulse
endmodule : pin_partner

// ### bench/test_octal_register_clear_hold.sv
/*
 Self-checking bench for the octal register: pins through pin_partner,
 registers through an AXI4-Lite master of its own.
 Assumes octal_reg_defines.svh is on the include path.
*/
`timescale 1ns/100ps
`include "octal_reg_defines.svh"

module test_octal_register_clear_hold
    import octal_reg_pkg::*;
;
    logic aclk, aresetn, edge_clock, zeroize_n, hold_n, q_bus_oe_n;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [2:0] gate_n;
    word_t data_in, q_bus_o, exp_word;
    addr_t awaddr, araddr;
    bus_word_t wdata, rdata;
    resp_t bresp, rresp;
    int failures, checked, n_loads;
    logic [15:0] seed;
    logic [33:0] rq[$];
    resp_t bq[$];

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    octal_register u_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .edge_clock(edge_clock), .data_in(data_in), .zeroize_n(zeroize_n),
        .hold_n(hold_n), .drive_gate_1_n(gate_n[0]), .drive_gate_2_n(gate_n[1]),
        .drive_gate_3_n(gate_n[2]), .q_bus_o(q_bus_o), .q_bus_oe_n(q_bus_oe_n),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp));

    pin_partner u_far (.aclk(aclk), .edge_clock(edge_clock), .data_in(data_in),
        .zeroize_n(zeroize_n), .hold_n(hold_n), .gate_n(gate_n));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function automatic bus_word_t status(input logic drv, input logic z, input logic h);
        return {15'h0000, 1'b1, 5'h00, h, z, drv, exp_word};
    endfunction : status

    task automatic results();
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    task automatic compare(input logic [33:0] got, input logic [33:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : compare

    task automatic check_pins(input logic oe_n);
        compare({25'h0000000, q_bus_oe_n, q_bus_o}, {25'h0000000, oe_n, exp_word});
    endtask : check_pins

    task automatic tick_bound(inout int n);
        n++;
        if (n > 200) begin
            failures++;
            results();
        end
    endtask : tick_bound

    task automatic axi_write(input addr_t a, input bus_word_t d, input resp_t r);
        int n;
        logic aw_done, w_done;
        n = 0;
        aw_done = 1'b0;
        w_done = 1'b0;
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            tick_bound(n);
            if (!aw_done && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            tick_bound(n);
        end while (!bvalid);
        bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_write

    task automatic axi_read(input addr_t a, input resp_t r, input bus_word_t d);
        int n;
        n = 0;
        rq.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            tick_bound(n);
        end while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            tick_bound(n);
        end while (!rvalid);
        rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_read

    // Results are taken from the queues in the order they were requested
    always @(posedge aclk) begin
        if (rvalid && rready) begin
            compare({rresp, rdata}, rq.pop_front());
        end
        if (bvalid && bready) begin
            compare({32'h00000000, bresp}, {32'h00000000, bq.pop_front()});
        end
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        awaddr = 4'h0;
        araddr = 4'h0;
        wdata = 32'h00000000;
        failures = 0;
        checked = 0;
        n_loads = 0;
        seed = 16'h740B;
        exp_word = 8'h00;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        check_pins(1'b1);
        axi_read(`CTRL_OFF, `RESP_OKAY, 32'h00000000);
        axi_read(4'hC, `RESP_SLVERR, 32'h00000000);
        axi_write(4'hC, 32'hFFFFFFFF, `RESP_SLVERR);
        axi_read(`CNT_OFF, `RESP_OKAY, 32'h00000000);
        // First load goes in while floating; the rest back to back while driving
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            u_far.pins(1'b1, 1'b0, (i == 0) ? 3'h7 : 3'h0);
            u_far.pulse(seed[7:0]);
            exp_word = seed[7:0];
            n_loads++;
            check_pins(i == 0);
            if (i == 0) begin
                axi_read(`STAT_OFF, `RESP_OKAY, status(1'b0, 1'b0, 1'b0));
            end
        end
        for (int g = 1; g < 8; g = g * 2) begin
            u_far.pins(1'b1, 1'b0, g[2:0]);
            check_pins(1'b1);
        end
        u_far.pins(1'b1, 1'b1, 3'h0);
        check_pins(1'b0);
        u_far.pulse(~exp_word);
        check_pins(1'b0);
        axi_read(`STAT_OFF, `RESP_OKAY, status(1'b1, 1'b0, 1'b1));
        u_far.pins(1'b1, 1'b0, 3'h0);
        axi_write(`CTRL_OFF, 32'h00000001, `RESP_OKAY);
        u_far.pulse(~exp_word);
        check_pins(1'b0);
        axi_write(`CTRL_OFF, 32'h00000004, `RESP_OKAY);
        repeat (3) @(posedge aclk);
        check_pins(1'b1);
        axi_write(`CTRL_OFF, 32'h00000000, `RESP_OKAY);
        // Zeroize with hold also active and no clock edge at all
        u_far.pins(1'b0, 1'b1, 3'h0);
        exp_word = 8'h00;
        check_pins(1'b0);
        axi_read(`STAT_OFF, `RESP_OKAY, status(1'b1, 1'b1, 1'b1));
        u_far.pins(1'b0, 1'b1, 3'h2);
        check_pins(1'b1);
        u_far.pins(1'b0, 1'b0, 3'h0);
        u_far.pulse(8'hA5);
        check_pins(1'b0);
        u_far.pins(1'b1, 1'b0, 3'h0);
        check_pins(1'b0);
        seed = lfsr(seed);
        u_far.pulse(seed[7:0]);
        exp_word = seed[7:0];
        n_loads++;
        check_pins(1'b0);
        axi_read(`CNT_OFF, `RESP_OKAY, n_loads);
        axi_write(`STAT_OFF, 32'h00010000, `RESP_OKAY);
        axi_read(`STAT_OFF, `RESP_OKAY, status(1'b1, 1'b0, 1'b0) & 32'hFFFEFFFF);
        axi_write(`CNT_OFF, 32'h00000000, `RESP_OKAY);
        axi_read(`CNT_OFF, `RESP_OKAY, 32'h00000000);
        results();
    end
endmodule : test_octal_register_clear_hold
